/* design/srwp_sync2.sv */
`timescale 1ns/1ps
module srwp_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            synced <= '0;
        end else begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule : srwp_sync2

/* design/srwp_top.sv */
`timescale 1ns/1ps
module srwp_top #(
    parameter int NV_CYCLES = srwp_pkg::WC_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOeN,
    input  wire logic       wp,
    input  wire logic       arrWrReq,
    input  wire logic [7:0] arrWrAddr,
    output logic            arrWrGrant,
    output logic            arrWrDeny,
    output logic            dcpVolWrOk,
    output logic            dcpNvWrOk,
    output logic            deviceActive,
    output logic            nvWriteBusy,
    output logic [7:0]      ctrlStatus
);
    srwp_pkg::srwp_state_s q;
    srwp_pkg::srwp_state_s d;
    logic [2:0] pinSync;
    logic       sclS;
    logic       sdaS;
    logic       wpS;
    logic       sclRise;
    logic       sclFall;
    logic       startEv;
    logic       stopEv;
    logic [7:0] statusView;
    logic       arrLocked;
    logic       csrOk;
    localparam int TmrW = srwp_pkg::TMR_W;

    // pins are asynchronous to sys_clk
    srwp_sync2 #(.WIDTH(3)) u_sync (
        .clk    (sys_clk),
        .reset  (reset),
        .async  ({scl, sdaIn, wp}),
        .synced (pinSync)
    );
    assign sclS = pinSync[2];
    assign sdaS = pinSync[1];
    assign wpS  = pinSync[0];

    // bus events from the synchronised levels
    assign sclRise = sclS & ~q.sclPrev;
    assign sclFall = ~sclS & q.sclPrev;
    assign startEv = sclS & q.sclPrev & q.sdaPrev & ~sdaS;
    assign stopEv  = sclS & q.sclPrev & ~q.sdaPrev & sdaS;

    // reserved positions are forced, not stored
    assign statusView = {srwp_pkg::RESV_UPPER, q.bl, q.register_write_enable_latch, q.write_enable_latch,
                         srwp_pkg::RESV_LOW};

    // locked partition decode
    always_comb begin
        unique case (q.bl)
            srwp_pkg::LOCK_NONE: arrLocked = 1'b0;
            srwp_pkg::LOCK_QTR:  arrLocked = arrWrAddr >= srwp_pkg::QTR_BASE;
            srwp_pkg::LOCK_HALF: arrLocked = arrWrAddr >= srwp_pkg::HALF_BASE;
            srwp_pkg::LOCK_ALL:  arrLocked = 1'b1;
        endcase
    end

    // decides whether a register data byte is acknowledged
    function automatic logic csr_accept(
        input logic [7:0] v,
        input logic       write_enable_latch,
        input logic       register_write_enable_latch,
        input logic       wpHi,
        input logic       busy
    );
        logic ok;
        ok = 1'b0;
        if (v == srwp_pkg::CSR_CLEAR) begin
            ok = 1'b1;
        end else if ((v & srwp_pkg::RESV_MASK) != srwp_pkg::CSR_CLEAR ||
                     !v[srwp_pkg::WEL_BIT]) begin
            ok = 1'b0;
        end else if (!write_enable_latch) begin
            ok = (v == srwp_pkg::CSR_WEL_SET);
        end else if (v[srwp_pkg::REGISTER_WRITE_ENABLE_LATCH_BIT]) begin
            ok = !wpHi;
        end else if (register_write_enable_latch) begin
            ok = !wpHi && !busy;
        end else begin
            ok = (v == srwp_pkg::CSR_WEL_SET);
        end
        return ok;
    endfunction : csr_accept

    assign csrOk = csr_accept(q.shift, q.write_enable_latch, q.register_write_enable_latch, wpS, q.nvBusy);

    // next state of the whole block
    always_comb begin
        d = q;
        d.sclPrev  = sclS;
        d.sdaPrev  = sdaS;
        d.arrGrant = 1'b0;
        d.arrDeny  = 1'b0;
        d.status   = statusView;
        d.dcpVolOk = q.write_enable_latch && (q.bl == srwp_pkg::LOCK_NONE);
        d.dcpNvOk  = q.write_enable_latch && (q.bl == srwp_pkg::LOCK_NONE) && !wpS &&
                     !q.nvBusy;
        // one down-counter serves standby delay and write cycle
        if (q.tmr != '0) begin
            d.tmr = q.tmr - TmrW'(1);
            if (q.tmr == TmrW'(1)) begin
                d.active = 1'b0;
                d.nvBusy = 1'b0;
            end
        end
        // array write permission, one answer per request
        if (arrWrReq) begin
            if (arrLocked) begin
                d.arrDeny = 1'b1;
                d.register_write_enable_latch    = 1'b0;
            end else if (q.write_enable_latch && !wpS && !q.nvBusy) begin
                d.arrGrant = 1'b1;
                d.nvBusy   = 1'b1;
                d.active   = 1'b1;
                d.tmr      = TmrW'(NV_CYCLES);
            end else begin
                d.arrDeny = 1'b1;
            end
        end
        if (startEv) begin
            d.active = 1'b1;
            d.fsm    = srwp_pkg::S_ADDR;
            d.bitCnt = '0;
            d.pendWr = 1'b0;
            d.sdaOeN = 1'b1;
            // a running write cycle keeps its timer
            if (!q.nvBusy) begin
                d.tmr = '0;
            end
        end else if (stopEv) begin
            d.fsm    = srwp_pkg::S_IDLE;
            d.sdaOeN = 1'b1;
            d.regSel = 1'b0;
            d.pendWr = 1'b0;
            if (!q.nvBusy) begin
                d.tmr = TmrW'(srwp_pkg::STBY_CYCLES);
                // only an acked byte with nothing after it counts
                if (q.fsm == srwp_pkg::S_WAIT_STOP &&
                    q.pendWr) begin
                    if (q.pendData == srwp_pkg::CSR_CLEAR) begin
                        d.write_enable_latch  = 1'b0;
                        d.register_write_enable_latch = 1'b0;
                    end else if (q.pendData[srwp_pkg::REGISTER_WRITE_ENABLE_LATCH_BIT]) begin
                        d.write_enable_latch  = 1'b1;
                        d.register_write_enable_latch = 1'b1;
                    end else if (q.register_write_enable_latch) begin
                        if (!wpS) begin
                            d.bl     = q.pendData[srwp_pkg::BL_HI:
                                                  srwp_pkg::BL_LO];
                            d.register_write_enable_latch   = 1'b0;
                            d.write_enable_latch    = 1'b1;
                            d.nvBusy = 1'b1;
                            d.tmr    = TmrW'(NV_CYCLES);
                        end
                    end else begin
                        d.write_enable_latch = 1'b1;
                    end
                end
            end
        end else begin
            unique case (q.fsm)
                srwp_pkg::S_IDLE: begin
                    d.sdaOeN = 1'b1;
                end
                srwp_pkg::S_ADDR, srwp_pkg::S_REGADDR, srwp_pkg::S_DATA_RX,
                srwp_pkg::S_ADDR_NACK, srwp_pkg::S_IGNORE: begin
                    if (sclRise) begin
                        d.shift  = {q.shift[6:0], sdaS};
                        d.bitCnt = q.bitCnt + 4'h1;
                        if (q.fsm == srwp_pkg::S_ADDR_NACK &&
                            d.bitCnt == srwp_pkg::MISS_EDGES) begin
                            d.fsm = srwp_pkg::S_IGNORE;
                            if (!q.nvBusy) begin
                                d.active = 1'b0;
                            end
                        end
                    end else if (sclFall &&
                                 q.bitCnt == srwp_pkg::BYTE_BITS) begin
                        if (q.fsm == srwp_pkg::S_ADDR) begin
                            // busy cycle: no ack, master may poll
                            if (q.shift[7:1] != srwp_pkg::DEV_ADDR ||
                                q.nvBusy) begin
                                d.fsm = srwp_pkg::S_ADDR_NACK;
                            end else if (q.shift[0] && !q.regSel) begin
                                d.fsm = srwp_pkg::S_IGNORE;
                            end else begin
                                d.fsm     = srwp_pkg::S_ACK;
                                d.sdaOeN  = 1'b0;
                                d.ackNext = q.shift[0] ? srwp_pkg::S_DATA_TX
                                                       : srwp_pkg::S_REGADDR;
                            end
                        end else if (q.fsm == srwp_pkg::S_REGADDR) begin
                            if (q.shift == srwp_pkg::CSR_ADDR) begin
                                d.fsm     = srwp_pkg::S_ACK;
                                d.sdaOeN  = 1'b0;
                                d.regSel  = 1'b1;
                                d.ackNext = srwp_pkg::S_DATA_RX;
                            end else begin
                                d.fsm = srwp_pkg::S_IGNORE;
                            end
                        end else if (q.fsm == srwp_pkg::S_DATA_RX) begin
                            if (csrOk) begin
                                d.fsm      = srwp_pkg::S_ACK;
                                d.sdaOeN   = 1'b0;
                                d.pendWr   = 1'b1;
                                d.pendData = q.shift;
                                d.ackNext  = srwp_pkg::S_WAIT_STOP;
                            end else begin
                                d.fsm = srwp_pkg::S_IGNORE;
                            end
                        end
                    end
                end
                srwp_pkg::S_ACK: begin
                    if (sclFall) begin
                        d.bitCnt = '0;
                        d.fsm    = q.ackNext;
                        d.sdaOeN = 1'b1;
                        // read leaves latches and pending write alone
                        if (q.ackNext == srwp_pkg::S_DATA_TX) begin
                            d.shift  = statusView;
                            d.sdaOeN = statusView[7];
                        end
                    end
                end
                srwp_pkg::S_WAIT_STOP: begin
                    // a stop also raises scl, so only a finished bit aborts
                    if (sclRise) begin
                        d.bitCnt = q.bitCnt + 4'h1;
                    end else if (sclFall && q.bitCnt != '0) begin
                        d.fsm    = srwp_pkg::S_IGNORE;
                        d.pendWr = 1'b0;
                    end
                end
                srwp_pkg::S_DATA_TX: begin
                    if (sclRise) begin
                        d.bitCnt = q.bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (q.bitCnt == srwp_pkg::BYTE_BITS) begin
                            d.sdaOeN = 1'b1;
                            d.fsm    = srwp_pkg::S_IGNORE;
                            d.bitCnt = '0;
                        end else begin
                            d.shift  = {q.shift[6:0], 1'b0};
                            d.sdaOeN = q.shift[6];
                        end
                    end
                end
            endcase
        end
    end

    // single register for all state except the pin synchroniser
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q        <= '0;
            q.sdaOeN <= 1'b1;
            q.bl     <= srwp_pkg::BL_RESET;
        end else begin
            q <= d;
        end
    end

    assign sdaOut       = q.sdaOut;
    assign sdaOeN       = q.sdaOeN;
    assign arrWrGrant   = q.arrGrant;
    assign arrWrDeny    = q.arrDeny;
    assign dcpVolWrOk   = q.dcpVolOk;
    assign dcpNvWrOk    = q.dcpNvOk;
    assign deviceActive = q.active;
    assign nvWriteBusy  = q.nvBusy;
    assign ctrlStatus   = q.status;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence txLastFall;
        q.fsm == srwp_pkg::S_DATA_TX && sclFall &&
        q.bitCnt == srwp_pkg::BYTE_BITS;
    endsequence

    sequence busReleased;
        q.sdaOeN && q.fsm == srwp_pkg::S_IGNORE;
    endsequence

    resv_read_zero_a: assert property (
        (q.status & srwp_pkg::RESV_MASK) == srwp_pkg::CSR_CLEAR)
        else $error("reserved status bits not zero");
    one_byte_read_a: assert property (
        txLastFall |=> busReleased ##1 q.sdaOeN)
        else $error("device kept driving after status byte");
    grant_needs_wel_a: assert property (
        q.arrGrant |-> $past(q.write_enable_latch) && !$past(wpS))
        else $error("array write granted without wel or with wp");
    register_write_enable_latch_needs_wel_a: assert property (
        $rose(q.register_write_enable_latch) |-> q.write_enable_latch)
        else $error("register_write_enable_latch set while wel clear");
    wp_blocks_nv_a: assert property (
        $rose(q.nvBusy) |-> !$past(wpS))
        else $error("nonvolatile cycle started with wp high");
    lock_blocks_dcp_a: assert property (
        $past(q.bl) != srwp_pkg::LOCK_NONE |-> !q.dcpVolOk && !q.dcpNvOk)
        else $error("potentiometer write allowed while locked");
    locked_array_deny_a: assert property (
        arrWrReq && arrLocked |=> q.arrDeny && !q.arrGrant &&
        (!q.register_write_enable_latch || $past(stopEv)))
        else $error("locked array write not refused");
    plain_stop_standby_a: assert property (
        stopEv && q.active && !q.nvBusy && !d.nvBusy |=>
        q.active && q.tmr == TmrW'(srwp_pkg::STBY_CYCLES))
        else $error("standby delay not armed after plain stop");
    standby_expiry_a: assert property (
        q.tmr == TmrW'(1) && !q.nvBusy && !startEv && !arrWrReq |=> !q.active)
        else $error("device still active after standby delay");
    nv_stays_active_a: assert property (
        $rose(q.nvBusy) |-> q.active [*8])
        else $error("device left active during write cycle");
    miss_standby_a: assert property (
        q.fsm == srwp_pkg::S_ADDR_NACK && sclRise && !q.nvBusy &&
        q.bitCnt == srwp_pkg::BYTE_BITS |=> !q.active)
        else $error("no standby after mismatched select");
    refuse_nack_a: assert property (
        q.fsm == srwp_pkg::S_DATA_RX && sclFall &&
        q.bitCnt == srwp_pkg::BYTE_BITS && !csrOk && !startEv &&
        !stopEv |=> q.sdaOeN [*2])
        else $error("refused data byte was acknowledged");
endmodule : srwp_top

/* shared/srwp_pkg.sv */
// Summary of operation
// - register read: select a5h, address ffh, one byte
// - one byte returned, then bus state resets
// - reads never disturb latched write sequence
// - reserved upper and low bits read zero
// - every write needs write enable latch first
// - register bits beyond wel need register_write_enable_latch set
// - write protect high blocks nonvolatile cycles
// - nonzero lock bits refuse potentiometer writes
// - wp low: locked partition refused, register allowed
// - wp high: array and register writes refused
// - nonvolatile cycle needs complete sequence before stop
// - mismatched select: standby nine clocks after start
// - plain stop: standby 200 ns later
// - launching stop: active through write cycle time
// - lock codes: none, c0h, 80h, whole array
// - 02h sets wel, 00h clears, reset clear
// - register_write_enable_latch clears after register write, locked access
// - refused write: data byte not acknowledged
package srwp_pkg;
    localparam logic [6:0] DEV_ADDR    = 7'h52;
    localparam logic [7:0] CSR_ADDR    = 8'hff;
    localparam logic [7:0] CSR_CLEAR   = 8'h00;
    localparam logic [7:0] CSR_WEL_SET = 8'h02;
    localparam logic [7:0] RESV_MASK   = 8'he1;
    localparam int         BL_HI       = 4;
    localparam int         BL_LO       = 3;
    localparam int         REGISTER_WRITE_ENABLE_LATCH_BIT    = 2;
    localparam int         WEL_BIT     = 1;
    localparam logic [2:0] RESV_UPPER  = 3'h0;
    localparam logic       RESV_LOW    = 1'h0;
    localparam logic [1:0] BL_RESET    = 2'h0;
    localparam logic [1:0] LOCK_NONE   = 2'h0;
    localparam logic [1:0] LOCK_QTR    = 2'h1;
    localparam logic [1:0] LOCK_HALF   = 2'h2;
    localparam logic [1:0] LOCK_ALL    = 2'h3;
    localparam logic [7:0] QTR_BASE    = 8'hc0;
    localparam logic [7:0] HALF_BASE   = 8'h80;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] MISS_EDGES  = 4'h9;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int STANDBY_NS     = 200;
    localparam int WRITE_CYCLE_MS = 10;
    localparam int STBY_CYCLES    = STANDBY_NS / CLK_PERIOD_NS;
    localparam int WC_CYCLES      = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TMR_W          = 20;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_NACK, S_ACK, S_REGADDR,
        S_DATA_RX, S_WAIT_STOP, S_DATA_TX, S_IGNORE
    } srwp_state_e;

    typedef struct packed {
        srwp_state_e      fsm;
        srwp_state_e      ackNext;
        logic [3:0]       bitCnt;
        logic [7:0]       shift;
        logic             regSel;
        logic             pendWr;
        logic [7:0]       pendData;
        logic             write_enable_latch;
        logic             register_write_enable_latch;
        logic [1:0]       bl;
        logic             active;
        logic             nvBusy;
        logic [TMR_W-1:0] tmr;
        logic             sclPrev;
        logic             sdaPrev;
        logic             sdaOeN;
        logic             sdaOut;
        logic             dcpVolOk;
        logic             dcpNvOk;
        logic             arrGrant;
        logic             arrDeny;
        logic [7:0]       status;
    } srwp_state_s;
endpackage : srwp_pkg

/* verif/srwp_bus_master.sv */
`timescale 1ns/1ps
module srwp_bus_master (
    input  wire logic linkClk,
    input  wire logic sdaOeN,
    output logic      scl,
    output logic      sdaIn
);
    logic mstSda; // 0 = master pulls the data line low

    // wired-and of both open-drain parties, pull-up when both release
    assign sdaIn = mstSda & sdaOeN;

    // bus idles high on both lines
    initial begin
        scl    = 1'b1;
        mstSda = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge linkClk);
    endtask : hold

    // one bit: data set while scl low, sampled mid high phase
    task automatic bit_c(input logic d, output logic s);
        mstSda <= d;
        hold(10);
        scl <= 1'b1;
        hold(10);
        s = sdaIn;
        hold(10);
        scl <= 1'b0;
        hold(10);
    endtask : bit_c

    // also serves as repeated start, since it raises both lines first
    task automatic start_c;
        mstSda <= 1'b1;
        hold(10);
        scl <= 1'b1;
        hold(10);
        mstSda <= 1'b0;
        hold(10);
        scl <= 1'b0;
        hold(10);
    endtask : start_c

    // every transaction closes with a stop
    task automatic stop_c;
        mstSda <= 1'b0;
        hold(10);
        scl <= 1'b1;
        hold(10);
        mstSda <= 1'b1;
        hold(3);
    endtask : stop_c

    // msb first, ninth clock released for the device acknowledge
    task automatic send8(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(b[i], s);
        end
        bit_c(1'b1, s);
        ack = ~s;
    endtask : send8

    task automatic recv8(input logic mAck, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s);
            b[i] = s;
        end
        bit_c(~mAck, s);
    endtask : recv8
endmodule : srwp_bus_master

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam int NV = 200;
    logic       sysClk;
    logic       linkClk;
    logic       reset;
    logic       scl;
    logic       sdaIn;
    logic       sdaOeN;
    logic       sdaOut;
    logic       wp;
    logic       arrWrReq;
    logic [7:0] arrWrAddr;
    logic       arrWrGrant;
    logic       arrWrDeny;
    logic       dcpVolWrOk;
    logic       dcpNvWrOk;
    logic       deviceActive;
    logic       nvWriteBusy;
    logic [7:0] ctrlStatus;
    logic       a;
    logic [1:0] st;
    logic [7:0] addrs [6] = '{8'h00, 8'h7f, 8'h80, 8'hbf, 8'hc0, 8'hff};
    int         errors = 0;
    int         nTests = 0;

    srwp_top #(.NV_CYCLES(NV)) u_dut (
        .sys_clk(sysClk), .reset(reset), .scl(scl), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .wp(wp), .arrWrReq(arrWrReq),
        .arrWrAddr(arrWrAddr), .arrWrGrant(arrWrGrant),
        .arrWrDeny(arrWrDeny), .dcpVolWrOk(dcpVolWrOk),
        .dcpNvWrOk(dcpNvWrOk), .deviceActive(deviceActive),
        .nvWriteBusy(nvWriteBusy), .ctrlStatus(ctrlStatus));

    srwp_bus_master u_mst (
        .linkClk(linkClk), .sdaOeN(sdaOeN), .scl(scl), .sdaIn(sdaIn));

    // link clock offset so its edges never line up with the system clock
    initial begin
        sysClk = 1'b0;
        forever #5 sysClk = ~sysClk;
    end
    initial begin
        linkClk = 1'b0;
        #1.3;
        forever #3 linkClk = ~linkClk;
    end

    task automatic test_done;
        if (errors == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // look just after the edge so registered outputs have settled
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        #1;
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic chk1(input logic got, input logic exp);
        check({7'h0, got}, {7'h0, exp});
    endtask : chk1

    // register write: select, register address, one data byte, stop
    task automatic wr(input logic [7:0] d, input logic expAck);
        u_mst.start_c();
        u_mst.send8(8'ha4, a);
        u_mst.send8(srwp_pkg::CSR_ADDR, a);
        u_mst.send8(d, a);
        chk1(a, expAck);
        u_mst.stop_c();
        repeat (5) @(posedge sysClk);
    endtask : wr

    // random read of the register; more=1 asks for a second byte
    task automatic rd(input logic [7:0] exp, input logic more);
        logic [7:0] v;
        u_mst.start_c();
        u_mst.send8(8'ha4, a);
        u_mst.send8(srwp_pkg::CSR_ADDR, a);
        u_mst.start_c();
        u_mst.send8(8'ha5, a);
        chk1(a, 1'b1);
        u_mst.recv8(more, v);
        check(v, exp);
        check(v & srwp_pkg::RESV_MASK, 8'h00);
        if (more) begin
            u_mst.recv8(1'b0, v);
            check(v, 8'hff);
        end
        u_mst.stop_c();
    endtask : rd

    // array request pulse, answer one cycle later, then let nv cycle end
    task automatic arr(input logic [7:0] ad, input logic g);
        @(posedge sysClk);
        arrWrReq  <= 1'b1;
        arrWrAddr <= ad;
        @(posedge sysClk);
        arrWrReq <= 1'b0;
        @(negedge sysClk);
        check({6'h0, arrWrGrant, arrWrDeny}, {6'h0, g, ~g});
        repeat (NV + 4) @(posedge sysClk);
    endtask : arr

    // the run needs about 240 us; two and a half times that means a hang
    initial begin
        #600000;
        errors++;
        test_done();
    end

    initial begin
        reset     = 1'b1;
        wp        = 1'b0;
        arrWrReq  = 1'b0;
        arrWrAddr = 8'h00;
        repeat (4) @(posedge sysClk);
        reset <= 1'b0;
        repeat (6) @(posedge sysClk);
        check(ctrlStatus, 8'h00);
        chk1(deviceActive, 1'b0);
        chk1(sdaOut, 1'b0);
        rd(8'h00, 1'b1);
        wr(8'h06, 1'b0);
        check(ctrlStatus, 8'h00);
        wr(8'h02, 1'b1);
        chk1(deviceActive, 1'b1);
        repeat (25) @(posedge sysClk);
        chk1(deviceActive, 1'b0);
        check(ctrlStatus, 8'h02);
        wr(8'h0a, 1'b0);
        wr(8'h06, 1'b1);
        wr(8'h8e, 1'b0);
        // stop after half a data byte must not launch anything
        u_mst.start_c();
        u_mst.send8(8'ha4, a);
        u_mst.send8(srwp_pkg::CSR_ADDR, a);
        for (int i = 0; i < 4; i++) begin
            u_mst.bit_c(1'b1, a);
        end
        u_mst.stop_c();
        repeat (5) @(posedge sysClk);
        chk1(nvWriteBusy, 1'b0);
        // a second data byte drops the pending register write
        u_mst.start_c();
        u_mst.send8(8'ha4, a);
        u_mst.send8(srwp_pkg::CSR_ADDR, a);
        u_mst.send8(8'h1a, a);
        chk1(a, 1'b1);
        u_mst.send8(8'h1a, a);
        chk1(a, 1'b0);
        u_mst.stop_c();
        repeat (5) @(posedge sysClk);
        chk1(nvWriteBusy, 1'b0);
        rd(8'h06, 1'b0);
        // mismatched select, then a wrong register address
        u_mst.start_c();
        u_mst.send8(8'h90, a);
        chk1(a, 1'b0);
        chk1(deviceActive, 1'b0);
        u_mst.stop_c();
        u_mst.start_c();
        u_mst.send8(8'ha4, a);
        u_mst.send8(8'h10, a);
        chk1(a, 1'b0);
        u_mst.stop_c();
        // every lock code, ending at none for the protect pin cases
        for (int k = 3; k >= 0; k--) begin
            st = k[1:0];
            wr(8'h06, 1'b1);
            wr({3'h0, st, 3'h2}, 1'b1);
            chk1(nvWriteBusy, 1'b1);
            chk1(deviceActive, 1'b1);
            repeat (NV) @(posedge sysClk);
            chk1(deviceActive, 1'b0);
            check(ctrlStatus, {3'h0, st, 3'h2});
            chk1(dcpVolWrOk, st == 2'h0);
            foreach (addrs[j]) begin
                arr(addrs[j], !(st == 2'h3 || (st == 2'h2 && addrs[j][7])
                    || (st == 2'h1 && addrs[j][7:6] == 2'h3)));
            end
            if (st != 2'h0) begin
                wr(8'h06, 1'b1);
                arr(8'hff, 1'b0);
                check(ctrlStatus, {3'h0, st, 3'h2});
            end
        end
        wp <= 1'b1;
        repeat (5) @(posedge sysClk);
        chk1(dcpNvWrOk, 1'b0);
        chk1(dcpVolWrOk, 1'b1);
        arr(8'h00, 1'b0);
        wr(8'h06, 1'b0);
        wp <= 1'b0;
        repeat (5) @(posedge sysClk);
        chk1(dcpNvWrOk, 1'b1);
        arr(8'hff, 1'b1);
        wr(8'h00, 1'b1);
        check(ctrlStatus, 8'h00);
        wr(8'h06, 1'b0);
        test_done();
    end
endmodule : tb
